//--- inc/scad_pkg.sv
// constants and types for the stacked-card address decoder
// assumes an 8-bit cpu bus with 16-bit addresses and 8-bit i/o port numbers
package scad_pkg;
  // memory map
  localparam logic [15:0] SCAD_UPPER_BASE = 16'h8000;
  localparam int SCAD_ADDR_MSB = 15;
  // i/o map: parallel port pair occupies a 32-port range
  localparam logic [7:0] SCAD_PIO_BASE = 8'h40;
  localparam logic [7:0] SCAD_PIO_LAST = 8'h5F;
  // lower-region select and bank control ports (chosen in the unused range)
  localparam logic [7:0] SCAD_SEL_PORT = 8'hC0;
  localparam logic [7:0] SCAD_BANK_PORT = 8'hC1;
  // bank select field
  localparam int SCAD_BANK_W = 4;
  localparam logic [3:0] SCAD_BANK_RESET = 4'h0;
  // ram size codes: 0 = 32K (1 bank), 1 = 128K (4 banks), 2 = 512K (16 banks)
  localparam logic [1:0] SCAD_SIZE_32K = 2'h0;
  localparam logic [1:0] SCAD_SIZE_128K = 2'h1;
  localparam logic [1:0] SCAD_SIZE_512K = 2'h2;
  // parallel port layout
  localparam int SCAD_SERIAL_BIT = 7;
  localparam logic [7:0] SCAD_OUT_RESET = 8'hFF;
  // timer tick: 1 ms at 50 MHz
  localparam int SCAD_CLOCK_HZ = 50000000;
  localparam int SCAD_TICK_US = 1000;
  localparam int SCAD_TICK_CYCLES = SCAD_CLOCK_HZ / 1000000 * SCAD_TICK_US;
  localparam int SCAD_TICK_W = 16;
  // lower region source
  typedef enum logic [0:0] {
    SCAD_LOW_ROM = 1'b0,
    SCAD_LOW_RAM = 1'b1
  } scad_low_e;
  typedef struct packed {
    logic [7:0] out_latch;
    logic [7:0] in_meta;
    logic [7:0] in_sync;
    scad_low_e low_sel;
    logic [3:0] bank;
    logic [15:0] tick_cnt;
    logic tick_irq;
  } scad_state_s;
endpackage

//--- src/scad_decoder.sv
// stacked-card address decoder, bank selector, parallel port pair and timer tick
// assumes a synchronous cpu bus on i_clock with one-cycle request strobes
//
// Overview of operation
// [RULE_01] addresses 8000-FFFF always select on-board ram
// [RULE_02] lower 32K maps to rom or banked ram
// [RULE_03] reset selects rom for lower region
// [RULE_04] bank value picks one 32K ram window
// [RULE_05] bank counts 1, 4 or 16 by ram size
// [RULE_06] port 0x40 read returns input pins, no side effect
// [RULE_07] port 0x40 write latches outputs, msb is tx
// [RULE_08] input port msb carries serial receive
// [RULE_09] software serial runs 9600 8N1 on msbs
// [RULE_10] panel card gives 1 ms tick interrupt
// [RULE_11] panel display driven only via cpu ports
// [RULE_12] ports 0x40-0x5F select port pair, others none
`timescale 1ns/1ps
`default_nettype none
module scad_decoder
  import scad_pkg::*;
#(
  parameter int TICK_CYCLES = SCAD_TICK_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_reset,
  // cpu memory bus
  input wire logic [15:0] i_addr,
  input wire logic i_mem_req,
  // cpu i/o bus
  input wire logic [7:0] i_port,
  input wire logic i_io_rd,
  input wire logic i_io_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  // configuration straps
  input wire logic [1:0] i_ram_size,
  input wire logic i_front_panel_card,
  // memory selects
  output logic o_ram_sel,
  output logic o_rom_sel,
  output logic o_xram_sel,
  output logic [18:0] o_xram_addr,
  // parallel port pins
  input wire logic [7:0] i_par_in,
  output logic [7:0] o_par_out,
  output logic o_output_bit_seven_pin,
  output logic o_pio_sel,
  // periodic interrupt to cpu
  output logic o_tick_irq
);

  scad_state_s state_reg;
  scad_state_s state_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic valid_reg;
  logic valid_next;
  logic panel_meta_reg;
  logic panel_reg;

  // true when a port number falls in the parallel pair range
  function automatic logic pio_hit(input logic [7:0] port);
    pio_hit = (port >= SCAD_PIO_BASE) && (port <= SCAD_PIO_LAST);
  endfunction

  // mask a bank value to the fitted ram size so unused bank bits are ignored
  function automatic logic [3:0] bank_mask(input logic [3:0] b, input logic [1:0] sz);
    unique case (sz)
      SCAD_SIZE_32K: bank_mask = 4'h0;
      SCAD_SIZE_128K: bank_mask = {2'h0, b[1:0]};
      default: bank_mask = b;
    endcase
  endfunction

  // memory decode is combinational so the select settles within the bus cycle
  always_comb begin
    o_ram_sel = i_mem_req && i_addr[SCAD_ADDR_MSB]; // RULE_01
    o_rom_sel = i_mem_req && !i_addr[SCAD_ADDR_MSB] &&
      (state_reg.low_sel == SCAD_LOW_ROM); // RULE_02
    o_xram_sel = i_mem_req && !i_addr[SCAD_ADDR_MSB] &&
      (state_reg.low_sel == SCAD_LOW_RAM); // RULE_02
    o_xram_addr = {bank_mask(state_reg.bank, i_ram_size), i_addr[14:0]}; // RULE_04
    o_pio_sel = (i_io_rd || i_io_wr) && pio_hit(i_port); // RULE_12
  end

  // state update: port latch, input sync, bank control and tick counter
  always_comb begin
    state_next = state_reg;
    rdata_next = 8'h00;
    valid_next = 1'b0;
    // pins are asynchronous to the cpu clock
    state_next.in_meta = i_par_in;
    state_next.in_sync = state_reg.in_meta;
    if (i_io_wr && pio_hit(i_port)) begin
      state_next.out_latch = i_wdata; // RULE_07
    end
    if (i_io_wr && (i_port == SCAD_SEL_PORT)) begin
      state_next.low_sel = scad_low_e'(i_wdata[0]); // RULE_02
    end
    if (i_io_wr && (i_port == SCAD_BANK_PORT)) begin
      state_next.bank = bank_mask(i_wdata[3:0], i_ram_size); // RULE_05
    end
    // reads never alter state, undecoded ports read as zero
    if (i_io_rd) begin
      valid_next = 1'b1;
      if (pio_hit(i_port)) begin
        rdata_next = state_reg.in_sync; // RULE_06 RULE_08
      end else if (i_port == SCAD_SEL_PORT) begin
        rdata_next = {7'h00, state_reg.low_sel};
      end else if (i_port == SCAD_BANK_PORT) begin
        rdata_next = {4'h0, state_reg.bank};
      end
    end
    // tick runs only with the panel card fitted
    state_next.tick_irq = 1'b0;
    if (!panel_reg) begin
      state_next.tick_cnt = 16'h0000; // RULE_10
    end else if (state_reg.tick_cnt == 16'(TICK_CYCLES - 1)) begin
      state_next.tick_cnt = 16'h0000;
      state_next.tick_irq = 1'b1; // RULE_10
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + 16'h0001;
    end
  end

  // registers; reset puts rom in the lower region and idles tx high
  always_ff @(posedge i_clock) begin
    panel_meta_reg <= i_front_panel_card;
    panel_reg <= panel_meta_reg;
    if (i_reset) begin
      state_reg.out_latch <= SCAD_OUT_RESET;
      state_reg.in_meta <= 8'h00;
      state_reg.in_sync <= 8'h00;
      state_reg.low_sel <= SCAD_LOW_ROM; // RULE_03
      state_reg.bank <= SCAD_BANK_RESET;
      state_reg.tick_cnt <= 16'h0000;
      state_reg.tick_irq <= 1'b0;
      rdata_reg <= 8'h00;
      valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rdata_reg <= rdata_next;
      valid_reg <= valid_next;
    end
  end

  // outputs: display and keypad are driven by software through the port pair
  assign o_par_out = state_reg.out_latch; // RULE_11
  assign o_output_bit_seven_pin = state_reg.out_latch[SCAD_SERIAL_BIT]; // RULE_07 RULE_09
  assign o_rdata = rdata_reg;
  assign o_rdata_valid = valid_reg;
  assign o_tick_irq = state_reg.tick_irq;

endmodule
`default_nettype wire

//--- test/scad_cpu_model.sv
// cpu i/o bus master model: one-cycle strobes
// assumes tasks are called from one bench process
`timescale 1ns/1ps
`default_nettype none
module scad_cpu_model (
  input wire logic i_clock,
  output logic [7:0] o_port,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_data
);
  initial {o_port, o_rd, o_wr, o_data} = 18'h00000;
  // strobe 1 ns after the edge; on release the data lines show the inverse and the port holds
  task automatic cyc(input logic w, input logic [7:0] p, input logic [7:0] d);
    @(posedge i_clock) #1;
    {o_wr, o_rd, o_port, o_data} = {w, !w, p, d};
    @(posedge i_clock) #1;
    {o_wr, o_rd, o_data} = {2'b00, ~d};
  endtask
endmodule
`default_nettype wire

//--- test/scad_decoder_properties.sv
// port assertions for the decoder
// assumes a tick period of at least 9 cycles
`timescale 1ns/1ps
`default_nettype none
module scad_decoder_properties (
  input wire logic i_clock, i_reset, i_mem_req, i_io_rd, i_io_wr,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_port, i_wdata, o_par_out,
  input wire logic o_rdata_valid, o_ram_sel, o_rom_sel, o_xram_sel,
  input wire logic o_output_bit_seven_pin, o_pio_sel, o_tick_irq
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // port pair window
  wire hit = i_port inside {[8'h40:8'h5F]};
  upper_ram_a: assert property (o_ram_sel == (i_mem_req && i_addr[15])) else $error("ram");
  one_source_a: assert property (i_mem_req && !i_addr[15] |-> o_rom_sel != o_xram_sel)
    else $error("low src");
  reset_rom_a: assert property ($fell(i_reset) && i_mem_req && !i_addr[15] |-> o_rom_sel)
    else $error("rom");
  latch_wr_a: assert property (i_io_wr && hit |=> o_par_out == $past(i_wdata))
    else $error("latch");
  tx_bit_a: assert property (o_output_bit_seven_pin == o_par_out[7]) else $error("tx");
  rd_answer_a: assert property (o_rdata_valid == $past(i_io_rd)) else $error("valid");
  pio_sel_a: assert property (o_pio_sel == ((i_io_rd || i_io_wr) && hit)) else $error("pio");
  tick_gap_a: assert property (o_tick_irq |=> !o_tick_irq [*8]) else $error("tick");
endmodule
bind scad_decoder scad_decoder_properties u_props (.*);
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the decoder
// assumes the cpu model drives the i/o bus; bench drives memory bus, pins, straps
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import scad_pkg::*;
  logic i_clock = 1'b0, i_reset = 1'b1, i_mem_req = 1'b0, i_front_panel_card = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [1:0] i_ram_size = 2'h0;
  logic [7:0] i_par_in = 8'h00, i_port, i_wdata, o_rdata, o_par_out, v;
  logic [18:0] o_xram_addr;
  logic i_io_rd, i_io_wr, o_rdata_valid, o_ram_sel, o_rom_sel, o_xram_sel;
  logic o_output_bit_seven_pin, o_pio_sel, o_tick_irq;
  logic [7:0] q[$];
  int miscompares = 0, comparisons = 0, ticks;
  always #10 i_clock = ~i_clock;
  scad_cpu_model cpu (.i_clock(i_clock), .o_port(i_port), .o_rd(i_io_rd), .o_wr(i_io_wr),
    .o_data(i_wdata));
  // short tick keeps the run brief
  scad_decoder #(.TICK_CYCLES(16)) DUT (.*);
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // each read answer meets the oldest note
  // sampled mid-cycle so the registered answer has settled
  always @(negedge i_clock) if (o_rdata_valid === 1'b1) chk(o_rdata, q.pop_front());
  initial begin
    #200000;
    miscompares++;
    results();
  end
  initial begin
    void'($urandom(47));
    repeat (16) @(posedge i_clock);
    #1 i_reset = 1'b0;
    i_mem_req = 1'b1;
    // random bytes through random ports of the port window
    repeat (8) begin
      v = $urandom;
      i_par_in = v;
      cpu.cyc(1'b1, 8'h40 + 8'($urandom % 32), v);
      chk({o_par_out, o_output_bit_seven_pin}, {v, v[7]});
      q.push_back(v);
      cpu.cyc(1'b0, 8'h5F, 8'h00);
    end
    q.push_back(8'h00);
    cpu.cyc(1'b0, 8'h60, 8'h00);
    cpu.cyc(1'b1, SCAD_SEL_PORT, 8'h01);
    // every ram size, bank masked to its count
    for (int s = 0; s < 3; s++) begin
      i_ram_size = 2'(s);
      cpu.cyc(1'b1, SCAD_BANK_PORT, 8'h0F);
      i_addr = 16'h1234;
      #1 chk({o_xram_sel, o_rom_sel, o_xram_addr}, {2'b10, s == 0 ? 4'h0 : s == 1 ? 4'h3 : 4'hF,
        15'h1234});
      i_addr = 16'hFFFF;
      #1 chk({o_ram_sel, o_rom_sel, o_xram_sel}, 3'b100);
    end
    // second reset brings rom back
    i_addr = 16'h0100;
    i_reset = 1'b1;
    @(posedge i_clock) #1 i_reset = 1'b0;
    chk({o_rom_sel, o_xram_sel}, 2'b10);
    // five pulses fit in 90 cycles with the counter starting from zero after reset
    ticks = 0;
    i_front_panel_card = 1'b1;
    repeat (90) @(posedge i_clock) ticks += int'(o_tick_irq === 1'b1);
    chk(21'(ticks), 21'h5);
    i_front_panel_card = 1'b0;
    repeat (4) @(posedge i_clock);
    ticks = 0;
    repeat (40) @(posedge i_clock) ticks += int'(o_tick_irq === 1'b1);
    chk(21'(ticks), 21'h0);
    results();
  end
endmodule
`default_nettype wire
